//--- src/adcc_defines.svh
// register offsets, field positions, reset values and timing counts of the converter control block
// assumes a 32-bit AXI4-Lite bus with word-aligned registers
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH
`define ADCC_OFS_CTL0 4'h0
`define ADCC_OFS_CTL1 4'h4
`define ADCC_OFS_RESL 4'h8
`define ADCC_OFS_RESH 4'hC
`define ADCC_CTL0_RST 8'h00
`define ADCC_CTL1_RST 8'h00
`define ADCC_RES_RST 12'h000
`define ADCC_B_START 7
`define ADCC_B_BUSY 6
`define ADCC_B_EN 5
`define ADCC_B_ALIGN 4
`define ADCC_CH_HI 3
`define ADCC_SRC_HI 7
`define ADCC_SRC_LO 5
`define ADCC_DIV_HI 2
`define ADCC_CONV_TICKS 16
`define ADCC_RESP_OKAY 2'b00
`define ADCC_RESP_DECERR 2'b11
`endif

//--- src/adcc_pkg.sv
// types shared by the converter control block
// assumes nothing beyond the defines header
package adcc_pkg;
  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b01,
    ADCC_CONV = 2'b10
  } adcc_state_e;
  typedef enum logic [2:0] {
    ADCC_SRC_EXT = 3'h0,
    ADCC_SRC_BG = 3'h1,
    ADCC_SRC_R2 = 3'h2,
    ADCC_SRC_R3 = 3'h3,
    ADCC_SRC_R4 = 3'h4
  } adcc_src_e;
endpackage : adcc_pkg

//--- src/adcc_ctrl.sv
// control, sequencing and result registers of a 12-bit SAR converter, AXI4-Lite slave
// assumes the analog core holds adc_data settled on aclk when a conversion ends
//
// Contract
// (RQ1) each conversion yields a 12-bit unsigned result from an external pin or bandgap
// (RQ2) result is spread over read-only high and low byte registers
// (RQ3) align bit 0 gives left-justified bytes, 1 gives right-justified bytes
// (RQ4) result register bits carrying no result bit read as zero
// (RQ5) with the converter disabled the result registers keep their contents
// (RQ6) source 000 routes the external channel named by channel codes 0 to 7
// (RQ7) external source with channel codes 8 to 15 connects no pin
// (RQ8) source 001 routes the internal bandgap reference to the converter
// (RQ9) sources 010, 011, 100 route nothing internal; converter input tied to ground
// (RQ10) sources 101 to 111 behave like source 000
// (RQ11) software sets channel code 8 to 15 whenever an internal source is chosen
// (RQ12) conversion starts when the start bit is written high then low
// (RQ13) busy flag at bit 6 sets on start and clears on completion
// (RQ14) channel field in low four bits of control 0, source in top three of control 1
// (RQ15) a pin used as converter input loses digital function and pull-up
// (RQ16) enable bit 5 powers the converter; low switches it off
// (RQ17) clock field selects system clock divided by 1 to 128
// (RQ18) completion raises the converter interrupt request
// (RQ19) fixed parameterised conversion length; results load as busy clears
// (RQ20) a start sequence during a conversion is ignored
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defines.svh"
module adcc_ctrl #(
  parameter int CONV_TICKS = `ADCC_CONV_TICKS
) (
  input wire logic aclk, // system clock, 125 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [3:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [3:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [11:0] adc_data, // converter core result
  output logic adc_power_en, // converter core power
  output logic adc_clk_en, // conversion clock enable pulse
  output logic adc_converting, // core is sampling and converting
  output logic [2:0] adc_ext_chan, // external channel index
  output logic adc_ext_connect, // external channel switch closed
  output logic adc_bandgap_sel, // bandgap reference on converter input
  output logic adc_ground_sel, // converter input grounded
  output logic [7:0] pin_analog_mode, // pin digital function and pull-up off
  output logic conv_done_irq // one-cycle completion interrupt request
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] ctl0, next_ctl0;
  logic [7:0] ctl1, next_ctl1;
  logic [11:0] res_data, next_res_data;
  logic start_armed, next_start_armed;
  adcc_pkg::adcc_state_e state, next_state;
  logic [6:0] div_cnt, next_div_cnt;
  logic [15:0] tick_cnt, next_tick_cnt;
  logic done, next_done;
  logic aw_got, next_aw_got;
  logic w_got, next_w_got;
  logic [3:0] aw_addr, next_aw_addr;
  logic [7:0] w_byte, next_w_byte;
  logic w_strb0, next_w_strb0;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic wr_fire, start_pulse, tick, last_tick;
  logic [6:0] div_mask;
  logic [7:0] res_low, res_high;
  logic [2:0] src;
  logic ext_src;

  ////////////////////////////////////////////////////////////////////////////
  // source routing and result formatting
  assign src = ctl1[`ADCC_SRC_HI:`ADCC_SRC_LO]; // [RQ14]
  // 000 and 101..111 are the external selections
  assign ext_src = (src == adcc_pkg::ADCC_SRC_EXT) || (src > adcc_pkg::ADCC_SRC_R4); // [RQ10]
  assign adc_ext_chan = ctl0[2:0]; // [RQ6]
  // code 1xxx names no pin, so every switch stays open
  assign adc_ext_connect = ext_src && !ctl0[`ADCC_CH_HI]; // [RQ6] [RQ7]
  assign adc_bandgap_sel = (src == adcc_pkg::ADCC_SRC_BG); // [RQ8]
  assign adc_ground_sel = !ext_src && (src != adcc_pkg::ADCC_SRC_BG); // [RQ9]
  assign adc_power_en = ctl0[`ADCC_B_EN]; // [RQ16]
  assign adc_converting = (state == adcc_pkg::ADCC_CONV);
  assign conv_done_irq = done; // [RQ18]

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pin
      // selected pin keeps its analog role even while the core is off
      assign pin_analog_mode[gi] = adc_ext_connect && (ctl0[2:0] == 3'(gi)); // [RQ15]
    end
  endgenerate

  // unused positions are forced low for either alignment
  assign res_high = ctl0[`ADCC_B_ALIGN] ? {4'h0, res_data[11:8]} : res_data[11:4]; // [RQ3] [RQ4]
  assign res_low = ctl0[`ADCC_B_ALIGN] ? res_data[7:0] : {res_data[3:0], 4'h0}; // [RQ3] [RQ4]

  ////////////////////////////////////////////////////////////////////////////
  // conversion clock divider and sequencer
  assign div_mask = 7'((8'h01 << ctl1[`ADCC_DIV_HI:0]) - 8'h01); // [RQ17]
  assign tick = ((div_cnt & div_mask) == div_mask); // [RQ17]
  assign adc_clk_en = tick && adc_converting;
  assign last_tick = tick && (tick_cnt == 16'(CONV_TICKS - 1)); // [RQ19]
  assign wr_fire = aw_got && w_got && !bvalid;
  // falling write of the start bit after a rising one
  assign start_pulse = wr_fire && w_strb0 && (aw_addr == `ADCC_OFS_CTL0) && start_armed
    && !w_byte[`ADCC_B_START]; // [RQ12]

  always_comb
  begin
    next_state = state;
    next_div_cnt = div_cnt + 7'h01;
    next_tick_cnt = tick_cnt;
    next_done = 1'b0;
    next_res_data = res_data;
    case (state)
      adcc_pkg::ADCC_IDLE:
      begin
        // a start with the converter off is dropped
        if (start_pulse && ctl0[`ADCC_B_EN])
        begin
          next_state = adcc_pkg::ADCC_CONV; // [RQ13]
          next_div_cnt = 7'h00;
          next_tick_cnt = 16'h0000;
        end
      end
      adcc_pkg::ADCC_CONV:
      begin
        // start_pulse is not looked at here, so a restart cannot cut a conversion
        if (!ctl0[`ADCC_B_EN])
        begin
          next_state = adcc_pkg::ADCC_IDLE; // [RQ5] [RQ20]
        end
        else if (last_tick)
        begin
          next_state = adcc_pkg::ADCC_IDLE; // [RQ13]
          next_res_data = adc_data; // [RQ1] [RQ19]
          next_done = 1'b1; // [RQ18]
        end
        else if (tick)
        begin
          next_tick_cnt = tick_cnt + 16'h0001;
        end
      end
      default:
      begin
        next_state = adcc_pkg::ADCC_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= adcc_pkg::ADCC_IDLE;
      div_cnt <= 7'h00;
      tick_cnt <= 16'h0000;
      done <= 1'b0;
      res_data <= `ADCC_RES_RST;
    end
    else
    begin
      state <= next_state;
      div_cnt <= next_div_cnt;
      tick_cnt <= next_tick_cnt;
      done <= next_done;
      res_data <= next_res_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave and control registers
  assign s_axi_awready = !aw_got && !bvalid;
  assign s_axi_wready = !w_got && !bvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  always_comb
  begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_aw_addr = aw_addr;
    next_w_byte = w_byte;
    next_w_strb0 = w_strb0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_ctl0 = ctl0;
    next_ctl1 = ctl1;
    next_start_armed = start_armed;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_got = 1'b1;
      next_aw_addr = {s_axi_awaddr[3:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_got = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_strb0 = s_axi_wstrb[0];
    end
    if (wr_fire)
    begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `ADCC_RESP_OKAY;
      case (aw_addr)
        `ADCC_OFS_CTL0:
        begin
          if (w_strb0)
          begin
            // busy bit is not stored here; it reads from the sequencer
            next_ctl0 = w_byte & ~(8'h01 << `ADCC_B_BUSY); // [RQ14]
            next_start_armed = w_byte[`ADCC_B_START]; // [RQ12]
          end
        end
        `ADCC_OFS_CTL1:
        begin
          if (w_strb0)
          begin
            next_ctl1 = w_byte;
          end
        end
        `ADCC_OFS_RESL, `ADCC_OFS_RESH:
        begin
          next_bresp = `ADCC_RESP_OKAY; // [RQ2]
        end
        default:
        begin
          next_bresp = `ADCC_RESP_DECERR;
        end
      endcase
    end
    else if (bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid)
    begin
      next_rvalid = 1'b1;
      next_rresp = `ADCC_RESP_OKAY;
      case ({s_axi_araddr[3:2], 2'b00})
        `ADCC_OFS_CTL0: next_rdata = {24'h000000, ctl0[7], adc_converting, ctl0[5:0]}; // [RQ13]
        `ADCC_OFS_CTL1: next_rdata = {24'h000000, ctl1};
        `ADCC_OFS_RESL: next_rdata = {24'h000000, res_low}; // [RQ2]
        `ADCC_OFS_RESH: next_rdata = {24'h000000, res_high}; // [RQ2]
        default:
        begin
          next_rdata = 32'h00000000;
          next_rresp = `ADCC_RESP_DECERR;
        end
      endcase
    end
    else if (rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 4'h0;
      w_byte <= 8'h00;
      w_strb0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'b00;
      ctl0 <= `ADCC_CTL0_RST;
      ctl1 <= `ADCC_CTL1_RST;
      start_armed <= 1'b0;
    end
    else
    begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      aw_addr <= next_aw_addr;
      w_byte <= next_w_byte;
      w_strb0 <= next_w_strb0;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      ctl0 <= next_ctl0;
      ctl1 <= next_ctl1;
      start_armed <= next_start_armed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_start_sets_busy: assert property ( // [RQ12] [RQ13]
    start_pulse && ctl0[`ADCC_B_EN] && !adc_converting |=> adc_converting)
    else $error("busy did not set after start");
  a_done_clears_busy: assert property ( // [RQ13] [RQ19]
    done |-> !adc_converting && $past(adc_converting) && res_data == $past(adc_data))
    else $error("completion did not clear busy and load result");
  a_off_holds_result: assert property ( // [RQ5]
    !ctl0[`ADCC_B_EN] |=> $stable(res_data))
    else $error("result changed while disabled");
  a_left_align_zero: assert property ( // [RQ3] [RQ4]
    !ctl0[`ADCC_B_ALIGN] |-> res_low[3:0] == 4'h0 && res_high == res_data[11:4])
    else $error("left alignment wrong");
  a_right_align_zero: assert property ( // [RQ3] [RQ4]
    ctl0[`ADCC_B_ALIGN] |-> res_high[7:4] == 4'h0 && res_low == res_data[7:0])
    else $error("right alignment wrong");
  a_ext_route: assert property ( // [RQ6] [RQ7] [RQ10]
    (src == 3'h0 || src >= 3'h5) |-> adc_ext_connect == !ctl0[3] && !adc_ground_sel)
    else $error("external routing wrong");
  a_internal_route: assert property ( // [RQ8] [RQ9]
    (src inside {3'h1, 3'h2, 3'h3, 3'h4}) |-> !adc_ext_connect && pin_analog_mode == 8'h00
      && adc_bandgap_sel == (src == 3'h1) && adc_ground_sel == (src != 3'h1))
    else $error("internal routing wrong");
  a_conv_length: assert property ( // [RQ19] [RQ17]
    ctl1[2:0] == 3'h0 && !adc_converting ##1 adc_converting && ctl1[2:0] == 3'h0
      && ctl0[`ADCC_B_EN] |-> ##[1:300] done)
    else $error("conversion did not finish in time");
  a_restart_ignored: assert property ( // [RQ20]
    adc_converting && start_pulse && !last_tick && ctl0[`ADCC_B_EN] |=> adc_converting
      && tick_cnt >= $past(tick_cnt))
    else $error("start restarted a running conversion");
  a_done_irq: assert property ( // [RQ18]
    conv_done_irq |=> !conv_done_irq)
    else $error("interrupt request longer than one cycle");

  c_full_conv: cover property (start_pulse ##[1:300] done);
  c_right_align: cover property (done && ctl0[`ADCC_B_ALIGN]);
  c_bandgap_conv: cover property (done && adc_bandgap_sel);
  c_restart_busy: cover property (adc_converting && start_pulse);

endmodule : adcc_ctrl
`default_nettype wire

//--- sim/adcc_core_model.sv
// stand-in for the analog converter core behind the control block
// assumes the control block samples adc_data on aclk as a conversion ends
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model #(
  parameter logic [11:0] EXT_BASE = 12'hA5C, // code seen on channel 0
  parameter logic [11:0] BG_CODE = 12'h4D2 // code of the bandgap level
) (
  input wire logic aclk, // system clock
  input wire logic adc_power_en, // core power
  input wire logic [2:0] adc_ext_chan, // channel index
  input wire logic adc_ext_connect, // channel switch closed
  input wire logic adc_bandgap_sel, // bandgap on input
  input wire logic adc_ground_sel, // input grounded
  output logic [11:0] adc_data // conversion code
);
  logic [11:0] drift = 12'h000;
  // an open or unpowered input gives a code that moves every cycle
  always @(posedge aclk) drift <= drift + 12'h3B7;
  always_comb
  begin
    if (!adc_power_en) adc_data = drift;
    else if (adc_ground_sel) adc_data = 12'h000;
    else if (adc_bandgap_sel) adc_data = BG_CODE;
    else if (adc_ext_connect) adc_data = EXT_BASE + {9'h000, adc_ext_chan};
    else adc_data = drift;
  end
endmodule : adcc_core_model
`default_nettype wire

//--- sim/test_adc_control_and_result_regs.sv
// self-checking bench of the converter control block over AXI4-Lite
// assumes the core model answers on the same aclk
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defines.svh"
module test_adc_control_and_result_regs;
  localparam int TK = 2;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [11:0] adc_data;
  logic adc_power_en, adc_clk_en, adc_converting, adc_ext_connect;
  logic adc_bandgap_sel, adc_ground_sel, conv_done_irq;
  logic [2:0] adc_ext_chan;
  logic [7:0] pin_analog_mode;
  int err_total = 0;
  int n_tests = 0;
  int n_conv = 0;
  int n_irq = 0;
  int n_clk = 0;
  int i;
  adcc_ctrl #(.CONV_TICKS(TK)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .adc_data, .adc_power_en, .adc_clk_en,
    .adc_converting, .adc_ext_chan, .adc_ext_connect, .adc_bandgap_sel, .adc_ground_sel,
    .pin_analog_mode, .conv_done_irq);
  adcc_core_model core_u (.aclk, .adc_power_en, .adc_ext_chan, .adc_ext_connect,
    .adc_bandgap_sel, .adc_ground_sel, .adc_data);
  initial
  begin
    forever #4 aclk = ~aclk;
  end
  // busy length, tick and pulse counts are watched at the ports, not read back
  always @(posedge aclk)
  begin
    if (adc_converting === 1'b1) n_conv <= n_conv + 1;
    if (conv_done_irq === 1'b1) n_irq <= n_irq + 1;
    if (adc_clk_en === 1'b1) n_clk <= n_clk + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic hang();
    err_total++;
    conclude();
  endtask : hang
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 50) hang();
    chk("bresp", 32'h00000000, {30'h00000000, s_axi_bresp});
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 50) hang();
    d = s_axi_rdata;
    chk("rresp", 32'h00000000, {30'h00000000, s_axi_rresp});
  endtask : rd
  task automatic rc(input logic [3:0] a, input logic [7:0] exp, input string what);
    logic [31:0] d;
    rd(a, d);
    chk(what, {24'h000000, exp}, d);
  endtask : rc
  task automatic conv(input logic [7:0] c0, input logic [7:0] c1, input int cyc, input bit twice);
    int b, q, n, k;
    logic [31:0] d;
    wr(`ADCC_OFS_CTL1, c1);
    wr(`ADCC_OFS_CTL0, c0 | 8'h80);
    rc(`ADCC_OFS_CTL0, c0 | 8'h80, "armed, not busy");
    b = n_conv;
    q = n_irq;
    k = n_clk;
    wr(`ADCC_OFS_CTL0, c0);
    if (twice) wr(`ADCC_OFS_CTL0, c0 | 8'h80);
    if (twice) wr(`ADCC_OFS_CTL0, c0);
    for (n = 0; n < 400; n++)
    begin
      rd(`ADCC_OFS_CTL0, d);
      if (d[6] === 1'b0) break;
    end
    if (n == 400) hang();
    chk("busy cycles", 32'(cyc), 32'(n_conv - b));
    chk("done pulses", 32'(cyc > 0), 32'(n_irq - q));
    chk("clock ticks", 32'((cyc > 0) ? TK : 0), 32'(n_clk - k));
  endtask : conv
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`ADCC_OFS_CTL0, 8'h00, "control 0 reset");
    rc(`ADCC_OFS_CTL1, 8'h00, "control 1 reset");
    chk("pins after reset", 32'h00000001, {24'h000000, pin_analog_mode});
    $display("test reset done");
    for (i = 0; i < 8; i++) conv(8'h23, 8'(i), TK << i, 1'b0);
    chk("power on", 32'h00000001, {31'h00000000, adc_power_en});
    rc(`ADCC_OFS_RESH, 8'hA5, "high left");
    rc(`ADCC_OFS_RESL, 8'hF0, "low left");
    wr(`ADCC_OFS_CTL0, 8'h33);
    rc(`ADCC_OFS_RESH, 8'h0A, "high right");
    rc(`ADCC_OFS_RESL, 8'h5F, "low right");
    wr(`ADCC_OFS_RESL, 8'h00);
    rc(`ADCC_OFS_RESL, 8'h5F, "read-only low");
    $display("test divider and format done");
    for (i = 0; i < 8; i++)
    begin
      wr(`ADCC_OFS_CTL1, {i[2:0], 5'h00});
      wr(`ADCC_OFS_CTL0, 8'h39);
      chk("open channel", 32'h00000000, {31'h00000000, adc_ext_connect});
      chk("bandgap", 32'(i == 1), {31'h00000000, adc_bandgap_sel});
      chk("ground", 32'(i > 1 && i < 5), {31'h00000000, adc_ground_sel});
      chk("pins open", 32'h00000000, {24'h000000, pin_analog_mode});
      if (i == 0 || i > 4)
      begin
        wr(`ADCC_OFS_CTL0, 8'h35);
        chk("ext connect", 32'h00000001, {31'h00000000, adc_ext_connect});
        chk("ext chan", 32'h00000005, {29'h00000000, adc_ext_chan});
        chk("pins ext", 32'h00000020, {24'h000000, pin_analog_mode});
      end
    end
    conv(8'h39, 8'h20, TK, 1'b0);
    rc(`ADCC_OFS_RESH, 8'h04, "bandgap high");
    rc(`ADCC_OFS_RESL, 8'hD2, "bandgap low");
    conv(8'h39, 8'h40, TK, 1'b0);
    rc(`ADCC_OFS_RESL, 8'h00, "ground low");
    conv(8'h35, 8'hC0, TK, 1'b0);
    rc(`ADCC_OFS_RESH, 8'h0A, "ext high");
    rc(`ADCC_OFS_RESL, 8'h61, "ext low");
    $display("test sources done");
    conv(8'h15, 8'hC0, 0, 1'b0);
    chk("power off", 32'h00000000, {31'h00000000, adc_power_en});
    rc(`ADCC_OFS_RESL, 8'h61, "kept while off");
    wr(`ADCC_OFS_CTL1, 8'h07);
    wr(`ADCC_OFS_CTL0, 8'hB5);
    i = n_irq;
    wr(`ADCC_OFS_CTL0, 8'h35);
    chk("busy before abort", 32'h00000001, {31'h00000000, adc_converting});
    wr(`ADCC_OFS_CTL0, 8'h15);
    rc(`ADCC_OFS_CTL0, 8'h15, "aborted, not busy");
    rc(`ADCC_OFS_RESL, 8'h61, "kept after abort");
    chk("no done on abort", 32'(i), 32'(n_irq));
    conv(8'h23, 8'h07, TK * 128, 1'b1);
    $display("test disable and restart done");
    conclude();
  end
  initial
  begin
    #400000;
    hang();
  end
endmodule : test_adc_control_and_result_regs
`default_nettype wire
